/* ilsb_pkg.sv */
// package: constants, types and helpers of the integer logic/shift unit
package ilsb_pkg;

  localparam int XLEN = 64;
  localparam int NUM_GR = 128;
  localparam int GR_IDX_W = 7;
  localparam logic [6:0] ZERO_REG = 7'h00;
  localparam logic [6:0] IMM22_MAX_SRC = 7'h03;
  localparam logic [6:0] IMM14_W = 7'h0E;
  localparam logic [6:0] IMM22_W = 7'h16;
  localparam logic [6:0] FULL_LEN = 7'h40;
  localparam logic [2:0] SCALE_MIN = 3'h1;
  localparam logic [2:0] SCALE_MAX = 3'h4;
  localparam int PTR_SRC_HI = 31;
  localparam int PTR_SRC_LO = 30;
  localparam int PTR_DST_HI = 62;
  localparam int PTR_DST_LO = 61;
  localparam int PTR_LOW_HI = 31;

  typedef enum logic [4:0] {
    ILSB_OP_AND = 5'h00,
    ILSB_OP_OR = 5'h01,
    ILSB_OP_XOR = 5'h02,
    ILSB_OP_ANDCM = 5'h03,
    ILSB_OP_ADD = 5'h04,
    ILSB_OP_ADDP = 5'h05,
    ILSB_OP_SHLADDP = 5'h06,
    ILSB_OP_SXT = 5'h07,
    ILSB_OP_ZXT = 5'h08,
    ILSB_OP_SHL = 5'h09,
    ILSB_OP_SHR = 5'h0A,
    ILSB_OP_SHRU = 5'h0B,
    ILSB_OP_EXTR = 5'h0C,
    ILSB_OP_EXTRU = 5'h0D,
    ILSB_OP_DEP = 5'h0E,
    ILSB_OP_DEPZ = 5'h0F,
    ILSB_OP_SHRP = 5'h10,
    ILSB_OP_SHRI = 5'h11,
    ILSB_OP_SHRUI = 5'h12,
    ILSB_OP_SHLI = 5'h13,
    ILSB_OP_MOVL = 5'h14
  } ilsb_op_type;

  typedef enum logic [1:0] {
    ILSB_SRC_REG = 2'h0,
    ILSB_SRC_IMM = 2'h1,
    ILSB_SRC_IMM14 = 2'h2,
    ILSB_SRC_IMM22 = 2'h3
  } ilsb_src_type;

  typedef enum logic [1:0] {
    ILSB_EXT_8 = 2'h0,
    ILSB_EXT_16 = 2'h1,
    ILSB_EXT_32 = 2'h2
  } ilsb_ext_type;

  typedef struct packed {
    logic valid;
    ilsb_op_type op;
    ilsb_src_type src_kind;
    logic [GR_IDX_W-1:0] src1;
    logic [GR_IDX_W-1:0] src2;
    logic [GR_IDX_W-1:0] dest;
    logic [XLEN-1:0] imm;
    logic [5:0] pos;
    logic [6:0] len;
    ilsb_ext_type ext_w;
    logic [2:0] scale;
    logic dep_imm;
    logic dep_ones;
  } ilsb_req_type;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic [GR_IDX_W-1:0] dest;
    logic [XLEN-1:0] data;
  } ilsb_wb_type;

  localparam ilsb_wb_type WB_RESET = '0;

  function automatic logic [63:0] low_mask(input logic [6:0] n);
    low_mask = (n >= FULL_LEN) ? '1 : ((64'h1 << n) - 64'h1);
  endfunction : low_mask

  // sign bit is bit w-1; the shift pair keeps it to one expression
  function automatic logic [63:0] sign_ext64(input logic [63:0] v,
                                             input logic [6:0] w);
    logic [63:0] t;
    t = v << (FULL_LEN - w);
    sign_ext64 = $signed(t) >>> (FULL_LEN - w);
  endfunction : sign_ext64

endpackage : ilsb_pkg

/* ilsb_shift_unit.sv */
// shifter: variable shifts, field extract and deposit, funnel shift
`timescale 1ns/1ps
module ilsb_shift_unit (
  // operation
  input ilsb_pkg::ilsb_op_type op,
  input logic [5:0] pos,
  input logic [6:0] len,
  input logic dep_imm,
  input logic dep_ones,
  // operands
  input logic [63:0] a,
  input logic [63:0] b,
  // result
  output logic [63:0] result
);
  import ilsb_pkg::*;

  logic [6:0] room;
  logic [6:0] eff;
  logic [6:0] top;
  logic [63:0] m;
  logic [63:0] dm;
  logic [63:0] field;
  logic [63:0] dsrc;
  logic [63:0] base;
  logic [127:0] cat;
  logic sgn;

  // fields running past bit 63 are cut there
  always_comb begin
    room = FULL_LEN - {1'b0, pos};
    eff = (len > room) ? room : len;
    top = {1'b0, pos} + eff - 7'h01;
    m = low_mask(eff);
    dm = m << pos;
    field = (a >> pos) & m;
    sgn = (eff == 7'h00) ? 1'b0 : a[top[5:0]];
    dsrc = dep_imm ? {64{dep_ones}} : a;
    base = (op == ILSB_OP_DEPZ) ? '0 : b;
    cat = {a, b} >> pos;
  end

  always_comb begin
    case (op)
      ILSB_OP_SHL: result = a << b;
      ILSB_OP_SHR: result = $signed(a) >>> b;
      ILSB_OP_SHRU: result = a >> b;
      ILSB_OP_EXTR: result = field | (~m & {64{sgn}});
      ILSB_OP_EXTRU: result = field;
      ILSB_OP_DEP,
      ILSB_OP_DEPZ: result = (base & ~dm) | ((dsrc << pos) & dm);
      ILSB_OP_SHRP: result = cat[63:0];
      default: result = '0;
    endcase
  end

endmodule : ilsb_shift_unit

/* ilsb_unit.sv */
// integer logic, pointer, extend, shift and bit-field execution unit
`timescale 1ns/1ps
module ilsb_unit (
  // clock and reset
  input logic clk,
  input logic reset,
  // issued operation
  input ilsb_pkg::ilsb_req_type req,
  // write-back
  output ilsb_pkg::ilsb_wb_type wb
);
  import ilsb_pkg::*;

  // ==========================================================
  // general register file
  // ==========================================================
  // entry 0 is never written; reads of it are forced to zero
  logic [XLEN-1:0] gr_q [0:NUM_GR-1];

  function automatic logic [63:0] read_gr(input logic [6:0] idx);
    read_gr = (idx == ZERO_REG) ? '0 : gr_q[idx];
  endfunction : read_gr

  logic [XLEN-1:0] opa;
  logic [XLEN-1:0] opb;
  logic [XLEN-1:0] src_a;

  assign opa = read_gr(req.src1);
  assign opb = read_gr(req.src2);
  // immediate takes the first operand slot
  assign src_a = (req.src_kind == ILSB_SRC_REG) ? opa : req.imm;

  // ==========================================================
  // shifter and field operations
  // ==========================================================
  ilsb_op_type sh_op;
  logic [6:0] sh_len;
  logic [XLEN-1:0] sh_res;

  always_comb begin
    sh_op = req.op;
    sh_len = req.len;
    case (req.op)
      ILSB_OP_SHRI: begin
        sh_op = ILSB_OP_EXTR;
        sh_len = FULL_LEN - {1'b0, req.pos};
      end
      ILSB_OP_SHRUI: begin
        sh_op = ILSB_OP_EXTRU;
        sh_len = FULL_LEN - {1'b0, req.pos};
      end
      ILSB_OP_SHLI: begin
        sh_op = ILSB_OP_DEPZ;
        sh_len = FULL_LEN - {1'b0, req.pos};
      end
      default: begin
      end
    endcase
  end

  ilsb_shift_unit u_shift (
    .op(sh_op),
    .pos(req.pos),
    .len(sh_len),
    .dep_imm(req.dep_imm),
    .dep_ones(req.dep_ones),
    .a(opa),
    .b(opb),
    .result(sh_res)
  );

  // ==========================================================
  // adders
  // ==========================================================
  logic [XLEN-1:0] add_a;
  logic [XLEN-1:0] add_res;
  logic [XLEN-1:0] ptr_a;
  logic [XLEN-1:0] ptr_sum;
  logic [XLEN-1:0] ptr_res;

  always_comb begin
    case (req.src_kind)
      ILSB_SRC_IMM14: add_a = sign_ext64(req.imm, IMM14_W);
      ILSB_SRC_IMM22: add_a = sign_ext64(req.imm, IMM22_W);
      ILSB_SRC_IMM: add_a = req.imm;
      default: add_a = opa;
    endcase
  end

  // a move of a small constant is this add with the zero register
  assign add_res = add_a + opb;

  assign ptr_a = (req.op == ILSB_OP_SHLADDP) ? (opa << req.scale) : src_a;
  assign ptr_sum = ptr_a + opb;

  always_comb begin
    ptr_res = '0;
    ptr_res[PTR_LOW_HI:0] = ptr_sum[PTR_LOW_HI:0];
    ptr_res[PTR_DST_HI:PTR_DST_LO] = opb[PTR_SRC_HI:PTR_SRC_LO];
  end

  // ==========================================================
  // extension
  // ==========================================================
  logic [6:0] ext_bits;

  always_comb begin
    case (req.ext_w)
      ILSB_EXT_8: ext_bits = 7'h08;
      ILSB_EXT_16: ext_bits = 7'h10;
      default: ext_bits = 7'h20;
    endcase
  end

  // ==========================================================
  // result select
  // ==========================================================
  logic [XLEN-1:0] res;
  logic bad;
  ilsb_wb_type wb_d;
  ilsb_wb_type wb_q;

  always_comb begin
    res = '0;
    bad = 1'b0;
    case (req.op)
      ILSB_OP_AND: res = src_a & opb;
      ILSB_OP_OR: res = src_a | opb;
      ILSB_OP_XOR: res = src_a ^ opb;
      ILSB_OP_ANDCM: res = src_a & ~opb;
      ILSB_OP_ADD: begin
        res = add_res;
        // narrow encoding only reaches the first four registers
        bad = (req.src_kind == ILSB_SRC_IMM22) &&
              (req.src2 > IMM22_MAX_SRC);
      end
      ILSB_OP_ADDP: res = ptr_res;
      ILSB_OP_SHLADDP: begin
        res = ptr_res;
        bad = (req.src_kind != ILSB_SRC_REG) ||
              (req.scale < SCALE_MIN) ||
              (req.scale > SCALE_MAX);
      end
      ILSB_OP_SXT: res = sign_ext64(opa, ext_bits);
      ILSB_OP_ZXT: res = opa & low_mask(ext_bits);
      ILSB_OP_SHL,
      ILSB_OP_SHR,
      ILSB_OP_SHRU,
      ILSB_OP_EXTR,
      ILSB_OP_EXTRU,
      ILSB_OP_DEP,
      ILSB_OP_DEPZ,
      ILSB_OP_SHRP,
      ILSB_OP_SHRI,
      ILSB_OP_SHRUI,
      ILSB_OP_SHLI: res = sh_res;
      ILSB_OP_MOVL: res = req.imm;
      default: bad = 1'b1;
    endcase
  end

  always_comb begin
    wb_d.valid = req.valid;
    wb_d.illegal = req.valid & bad;
    wb_d.dest = req.dest;
    wb_d.data = bad ? '0 : res;
  end

  // ==========================================================
  // write-back stage
  // ==========================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_q <= WB_RESET;
    end else begin
      wb_q <= wb_d;
    end
  end

  // written on the same edge as wb, so a following op sees it
  always_ff @(posedge clk) begin
    if (!reset && wb_d.valid && !wb_d.illegal &&
        (wb_d.dest != ZERO_REG)) begin
      gr_q[wb_d.dest] <= wb_d.data;
    end
  end

  assign wb = wb_q;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_zero_read;
    req.valid && (req.src1 == ZERO_REG) |-> (opa == '0);
  endproperty
  a_zero_read: assert property (p_zero_read)
    else $error("zero register read nonzero");

  property p_one_result;
    req.valid |=> wb.valid && (wb.dest == $past(req.dest));
  endproperty
  a_one_result: assert property (p_one_result)
    else $error("issued op gave no write-back");

  property p_no_result;
    !req.valid |=> !wb.valid;
  endproperty
  a_no_result: assert property (p_no_result)
    else $error("write-back without issue");

  property p_and;
    req.valid && (req.op == ILSB_OP_AND)
      |=> wb.data == ($past(src_a) & $past(opb));
  endproperty
  a_and: assert property (p_and)
    else $error("and result wrong");

  property p_andcm;
    req.valid && (req.op == ILSB_OP_ANDCM)
      |=> wb.data == ($past(src_a) & ~$past(opb));
  endproperty
  a_andcm: assert property (p_andcm)
    else $error("and-not result wrong");

  property p_addp;
    req.valid && (req.op == ILSB_OP_ADDP)
      |=> (wb.data[63] == 1'b0) && (wb.data[60:32] == '0) &&
          (wb.data[62:61] == $past(opb[31:30]));
  endproperty
  a_addp: assert property (p_addp)
    else $error("pointer add region bits wrong");

  property p_shladdp_imm;
    req.valid && (req.op == ILSB_OP_SHLADDP) &&
      (req.src_kind != ILSB_SRC_REG) |=> wb.illegal;
  endproperty
  a_shladdp_imm: assert property (p_shladdp_imm)
    else $error("scaled pointer add took an immediate");

  property p_sxt8;
    req.valid && (req.op == ILSB_OP_SXT) && (req.ext_w == ILSB_EXT_8)
      |=> wb.data == {{56{$past(opa[7])}}, $past(opa[7:0])};
  endproperty
  a_sxt8: assert property (p_sxt8)
    else $error("8-bit sign extension wrong");

  property p_shr_fill;
    req.valid && (req.op == ILSB_OP_SHR) && opa[63] && (opb > 64'h3F)
      |=> wb.data == '1;
  endproperty
  a_shr_fill: assert property (p_shr_fill)
    else $error("signed shift did not fill with sign");

  property p_imm22_src;
    req.valid && (req.op == ILSB_OP_ADD) &&
      (req.src_kind == ILSB_SRC_IMM22) && (req.src2 > IMM22_MAX_SRC)
      |=> wb.illegal && (wb.data == '0);
  endproperty
  a_imm22_src: assert property (p_imm22_src)
    else $error("22-bit add accepted a high register");

  property p_rotate;
    req.valid && (req.op == ILSB_OP_SHRP) && (req.src1 == req.src2)
      |=> wb.data == (($past(opa) >> $past(req.pos)) |
          ($past(opa) << (FULL_LEN - {1'b0, $past(req.pos)})));
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("pair shift of one register not a rotate");

  property p_movl;
    req.valid && (req.op == ILSB_OP_MOVL) |=> wb.data == $past(req.imm);
  endproperty
  a_movl: assert property (p_movl)
    else $error("long move data wrong");

  property p_imm14;
    req.valid && (req.op == ILSB_OP_ADD) &&
      (req.src_kind == ILSB_SRC_IMM14)
      |=> wb.data == ({{50{$past(req.imm[13])}}, $past(req.imm[13:0])}
                      + $past(opb));
  endproperty
  a_imm14: assert property (p_imm14)
    else $error("14-bit immediate add wrong");

  property p_xor;
    req.valid && (req.op == ILSB_OP_XOR)
      |=> wb.data == ($past(src_a) ^ $past(opb));
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor result wrong");

  property p_shru_fill;
    req.valid && (req.op == ILSB_OP_SHRU) && (opb > 64'h3F)
      |=> wb.data == '0;
  endproperty
  a_shru_fill: assert property (p_shru_fill)
    else $error("unsigned shift did not fill with zeroes");

  property p_zxt32;
    req.valid && (req.op == ILSB_OP_ZXT) && (req.ext_w == ILSB_EXT_32)
      |=> wb.data == {32'h0, $past(opa[31:0])};
  endproperty
  a_zxt32: assert property (p_zxt32)
    else $error("32-bit zero extension wrong");

  property p_scale_high;
    req.valid && (req.op == ILSB_OP_SHLADDP) && (req.scale > SCALE_MAX)
      |=> wb.illegal && (wb.data == '0);
  endproperty
  a_scale_high: assert property (p_scale_high)
    else $error("scaled pointer add took a scale above four");

endmodule : ilsb_unit

/* ilsb_wb_sink.sv */
// partner model: write-back sink counting results and refusals
`timescale 1ns/1ps
module ilsb_wb_sink (
  // clock and reset
  input logic clk,
  input logic reset,
  // write-back from the unit
  input ilsb_pkg::ilsb_wb_type wb,
  // counts seen
  output int n_wb,
  output int n_ill
);
  import ilsb_pkg::*;
  // ==========
  // counting
  // every cycle with valid set is one result, written or refused, so count cycles not edges
  always_ff @(posedge clk) begin
    if (reset) begin
      n_wb <= 0;
      n_ill <= 0;
    end else if (wb.valid === 1'b1) begin
      n_wb <= n_wb + 1;
      n_ill <= n_ill + int'(wb.illegal);
    end
  end
endmodule : ilsb_wb_sink

/* integer_logic_shift_bitfield_unit_tb_top.sv */
// testbench of the integer logic, shift and bit-field unit
`timescale 1ns/1ps
module integer_logic_shift_bitfield_unit_tb_top;
  import ilsb_pkg::*;
  // ==========
  // signals
  localparam logic [63:0] VA = 64'h8123_4567_89AB_CDEF;
  localparam logic [63:0] VB = 64'hC0F0_F0F0_7C3C_C3C3;
  localparam ilsb_src_type KR = ILSB_SRC_REG;
  localparam ilsb_src_type KI = ILSB_SRC_IMM;
  localparam ilsb_src_type K14 = ILSB_SRC_IMM14;
  localparam ilsb_src_type K22 = ILSB_SRC_IMM22;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ilsb_req_type req = '0;
  ilsb_wb_type wb;
  int n_wb;
  int n_ill;
  int n_iss = 0;
  int n_bad = 0;
  int cyc = 0;
  int err_count = 0;
  int samples_checked = 0;

  ilsb_unit uut (
    .clk(clk),
    .reset(reset),
    .req(req),
    .wb(wb)
  );

  ilsb_wb_sink sink (
    .clk(clk),
    .reset(reset),
    .wb(wb),
    .n_wb(n_wb),
    .n_ill(n_ill)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========
  // helpers
  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic ilsb_req_type mk(input ilsb_op_type op,
      input ilsb_src_type k, input int s1, input int s2, input int d,
      input logic [63:0] imm);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
    mk.src_kind = k;
    mk.src1 = 7'(s1);
    mk.src2 = 7'(s2);
    mk.dest = 7'(d);
    mk.imm = imm;
  endfunction : mk

  // pointer result: low word of the sum, region bits of second source
  function automatic logic [63:0] pe(input logic [63:0] s);
    pe = {1'b0, VB[31:30], 29'h0, s[31:0]};
  endfunction : pe

  // entered at a falling edge; leaves req standing for back-to-back issue
  task automatic go(input ilsb_req_type q, input logic [63:0] e,
      input logic il);
    req = q;
    n_iss++;
    n_bad += int'(il);
    @(negedge clk);
    chk(64'(wb.valid), 64'h1);
    chk(64'(wb.illegal), 64'(il));
    chk(64'(wb.dest), 64'(q.dest));
    chk(wb.data, e);
  endtask : go

  task automatic idle(input string nm);
    req.valid = 1'b0;
    @(negedge clk);
    chk(64'(wb.valid), 64'h0);
    $display("test %s done", nm);
  endtask : idle

  // ==========
  // scenarios
  task automatic t_load();
    go(mk(ILSB_OP_MOVL, KI, 0, 0, 1, VA), VA, 0);
    go(mk(ILSB_OP_MOVL, KI, 0, 0, 2, VB), VB, 0);
    go(mk(ILSB_OP_OR, KR, 1, 0, 5, 0), VA, 0);
    go(mk(ILSB_OP_OR, KR, 0, 0, 5, 0), 64'h0, 0);
    idle("load");
  endtask : t_load

  task automatic t_logic();
    ilsb_op_type ops[4] = '{ILSB_OP_AND, ILSB_OP_OR, ILSB_OP_XOR,
                            ILSB_OP_ANDCM};
    logic [63:0] e[4] = '{VA & VB, VA | VB, VA ^ VB, VA & ~VB};
    for (int i = 0; i < 4; i++) begin
      go(mk(ops[i], KR, 1, 2, 3, 0), e[i], 0);
      go(mk(ops[i], KI, 0, 2, 3, VA), e[i], 0);
    end
    idle("logic");
  endtask : t_logic

  task automatic t_ptr();
    ilsb_req_type q;
    go(mk(ILSB_OP_ADDP, KR, 1, 2, 3, 0), pe(VA + VB), 0);
    go(mk(ILSB_OP_ADDP, KI, 0, 2, 3, VA), pe(VA + VB), 0);
    for (int s = 0; s < 6; s++) begin
      q = mk(ILSB_OP_SHLADDP, KR, 1, 2, 3, 0);
      q.scale = 3'(s);
      // out-of-range scales are refused with zero data
      go(q, (s == 0 || s == 5) ? 64'h0 : pe((VA << s) + VB),
         (s == 0 || s == 5));
    end
    q.src_kind = KI;
    q.scale = 3'h2;
    go(q, 64'h0, 1);
    idle("pointer");
  endtask : t_ptr

  task automatic t_ext();
    ilsb_req_type q;
    logic [63:0] v;
    logic [63:0] m;
    int n;
    for (int j = 1; j < 3; j++) begin
      for (int w = 0; w < 3; w++) begin
        v = (j == 1) ? VA : VB;
        n = 8 << w;
        m = (64'h1 << n) - 64'h1;
        q = mk(ILSB_OP_ZXT, KR, j, 0, 3, 0);
        q.ext_w = ilsb_ext_type'(w);
        go(q, v & m, 0);
        q.op = ILSB_OP_SXT;
        go(q, (v & m) | (v[n-1] ? ~m : 64'h0), 0);
      end
    end
    idle("extend");
  endtask : t_ext

  task automatic t_shift();
    int c[3] = '{4, 63, 64};
    for (int i = 0; i < 3; i++) begin
      go(mk(ILSB_OP_MOVL, KI, 0, 0, 3, 64'(c[i])), 64'(c[i]), 0);
      go(mk(ILSB_OP_SHL, KR, 1, 3, 4, 0), VA << c[i], 0);
      go(mk(ILSB_OP_SHR, KR, 1, 3, 4, 0), $signed(VA) >>> c[i], 0);
      go(mk(ILSB_OP_SHRU, KR, 1, 3, 4, 0), VA >> c[i], 0);
    end
    idle("shift");
  endtask : t_shift

  task automatic t_field();
    ilsb_req_type q;
    logic [63:0] m;
    m = 64'h0000_0000_00FF_0000;
    q = mk(ILSB_OP_EXTR, KR, 1, 2, 3, 0);
    q.pos = 6'h08;
    q.len = 7'h0C;
    go(q, 64'hFFFF_FFFF_FFFF_FBCD, 0);
    q.op = ILSB_OP_EXTRU;
    go(q, 64'h0000_0000_0000_0BCD, 0);
    q.op = ILSB_OP_EXTR;
    q.src1 = 7'h02;
    q.pos = 6'h1C;
    q.len = 7'h04;
    go(q, 64'h7, 0);
    q.pos = 6'h3C;
    q.len = 7'h08;
    go(q, 64'hFFFF_FFFF_FFFF_FFFC, 0);
    q.src1 = 7'h01;
    q.op = ILSB_OP_SHRI;
    q.pos = 6'h05;
    q.len = 7'h3B;
    go(q, $signed(VA) >>> 5, 0);
    q.op = ILSB_OP_SHRUI;
    go(q, VA >> 5, 0);
    q.op = ILSB_OP_SHLI;
    go(q, VA << 5, 0);
    q.op = ILSB_OP_DEP;
    q.pos = 6'h10;
    q.len = 7'h08;
    go(q, (VB & ~m) | ((VA << 16) & m), 0);
    q.op = ILSB_OP_DEPZ;
    go(q, (VA << 16) & m, 0);
    q.dep_imm = 1'b1;
    q.dep_ones = 1'b1;
    go(q, m, 0);
    q.op = ILSB_OP_DEP;
    go(q, VB | m, 0);
    q.dep_ones = 1'b0;
    go(q, VB & ~m, 0);
    idle("field");
  endtask : t_field

  task automatic t_pair();
    ilsb_req_type q;
    logic [127:0] c;
    c = {VA, VB} >> 12;
    q = mk(ILSB_OP_SHRP, KR, 1, 2, 3, 0);
    q.pos = 6'h0C;
    go(q, c[63:0], 0);
    q.src2 = 7'h01;
    go(q, {VA[11:0], VA[63:12]}, 0);
    q.src2 = 7'h02;
    q.pos = 6'h00;
    go(q, VB, 0);
    idle("pair");
  endtask : t_pair

  task automatic t_add();
    go(mk(ILSB_OP_MOVL, KI, 0, 0, 3, 64'h5), 64'h5, 0);
    go(mk(ILSB_OP_ADD, KR, 1, 2, 4, 0), VA + VB, 0);
    go(mk(ILSB_OP_ADD, KI, 0, 2, 4, VA), VA + VB, 0);
    go(mk(ILSB_OP_ADD, K14, 0, 2, 4, 64'h3FFF), VB - 64'h1, 0);
    go(mk(ILSB_OP_ADD, K14, 0, 2, 4, 64'h1FFF), VB + 64'h1FFF, 0);
    go(mk(ILSB_OP_ADD, K22, 0, 0, 4, 64'h1FFFFF), 64'h1FFFFF, 0);
    go(mk(ILSB_OP_ADD, K22, 0, 0, 4, 64'h200000), ~64'h1FFFFF, 0);
    go(mk(ILSB_OP_ADD, K22, 0, 3, 4, 64'h1), 64'h6, 0);
    go(mk(ILSB_OP_ADD, K22, 0, 4, 4, 64'h1), 64'h0, 1);
    go(mk(ilsb_op_type'(5'h1F), KR, 1, 2, 4, 0), 64'h0, 1);
    idle("add");
  endtask : t_add

  // ==========
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk(64'(wb.valid), 64'h0);
    chk(wb.data, 64'h0);
    t_load();
    t_logic();
    t_ptr();
    t_ext();
    t_shift();
    t_field();
    t_pair();
    t_add();
    chk(64'(n_wb), 64'(n_iss));
    chk(64'(n_ill), 64'(n_bad));
    test_done();
  end
endmodule : integer_logic_shift_bitfield_unit_tb_top
